// ---- src/sblwm_mem.v ----
// Two-word location memory with per-lane write enables and registered read
`timescale 1ns/1ps
`include "sblwm_regs.vh"
module sblwm_mem (
  input  wire                         clk_i,
  input  wire                         ce_i,
  input  wire                         we_i,
  input  wire [`SBLWM_LOC_W-1:0]      waddr_i,
  input  wire [2*`SBLWM_LANES-1:0]    wlane_i,
  input  wire [2*`SBLWM_WORD_W-1:0]   wdata_i,
  input  wire [`SBLWM_LOC_W-1:0]      raddr_i,
  output reg  [2*`SBLWM_WORD_W-1:0]   rdata_o
);
  reg [2*`SBLWM_WORD_W-1:0] mem [0:`SBLWM_DEPTH-1];
  genvar g;
  generate
    for (g = 0; g < 2*`SBLWM_LANES; g = g + 1) begin : lane
      // Only enabled lanes change, others keep contents
      always @(posedge clk_i) begin
        if (ce_i && we_i && wlane_i[g]) begin
          mem[waddr_i][g*`SBLWM_LANE_W +: `SBLWM_LANE_W] <=
            wdata_i[g*`SBLWM_LANE_W +: `SBLWM_LANE_W];
        end
      end
    end
  endgenerate
  always @(posedge clk_i) begin
    if (ce_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// ---- src/sblwm_regs.vh ----
// Constants for the byte lane write mask block
`ifndef SBLWM_REGS_VH
`define SBLWM_REGS_VH
`define SBLWM_LANE_W     9
`define SBLWM_LANES      4
`define SBLWM_WORD_W     36
`define SBLWM_LOC_W      8
`define SBLWM_LOC_W_M1   7
`define SBLWM_DEPTH      256
`define SBLWM_LOC_ZERO   8'h00
`define SBLWM_WORD_ZERO  36'h000000000
`define SBLWM_MASK_NONE  4'hf
`define SBLWM_MASK_X18   4'h3
`endif

// ---- src/sblwm_top.v ----
// Write port with per-beat byte lane masking into a two-word burst array
// Contract
// - x18: lane select 0 low writes [8:0], select 1 low writes [17:9]
// - x36: selects 0..3 low write [8:0],[17:9],[26:18],[35:27]
// - All selects high: no data written, write cycle still proceeds
// - Each beat applies its own lane pattern to its own word
// - Power-up deselected, read data outputs high impedance
// - First beat at base location, second at next burst address
// - Start cycle is t; following cycles are t+1 and t+2
// - Write data registered on rising edges of both input clocks
// - Read data launched on output clocks, input clocks in single mode
// - Lane selects sampled with each data word, once per beat
// - Deselected write port ignores inputs after pending write completes
`timescale 1ns/1ps
`include "sblwm_regs.vh"
module sblwm_top (
  input  wire                       CORE_CLK_I,
  input  wire                       RST_B_I,
  input  wire                       CE_I,
  input  wire                       WIDE_MODE_I,
  input  wire                       K_RISE_I,
  input  wire                       KN_RISE_I,
  input  wire                       C_RISE_I,
  input  wire                       CN_RISE_I,
  input  wire                       SINGLE_CLK_I,
  input  wire                       WRITE_PORT_SELECT_N_I,
  input  wire [`SBLWM_LOC_W-1:0]    ADDR_I,
  input  wire [`SBLWM_WORD_W-1:0]   WDATA_I,
  input  wire [`SBLWM_LANES-1:0]    BYTE_LANE_WRITE_SELECT_N_I,
  input  wire                       READ_I,
  input  wire [`SBLWM_LOC_W-1:0]    RADDR_I,
  output reg  [`SBLWM_WORD_W-1:0]   RDATA_O,
  output reg                        RDATA_OE_N_O,
  output reg                        WRITE_DONE_O,
  output reg                        WRITE_BUSY_O
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_BEAT1 = 3'b010;
  localparam ST_COMIT = 3'b100;
  localparam RD_IDLE  = 3'b001;
  localparam RD_LO    = 3'b010;
  localparam RD_HI    = 3'b100;

  reg  [2:0]                    st_q;
  reg  [2:0]                    st_d;
  reg  [2:0]                    rd_st_q;
  reg  [2:0]                    rd_st_d;
  reg  [`SBLWM_LOC_W-1:0]       loc_q;
  reg  [`SBLWM_LOC_W-1:0]       loc_d;
  reg  [`SBLWM_WORD_W-1:0]      d0_q;
  reg  [`SBLWM_WORD_W-1:0]      d0_d;
  reg  [`SBLWM_WORD_W-1:0]      d1_q;
  reg  [`SBLWM_WORD_W-1:0]      d1_d;
  reg  [`SBLWM_LANES-1:0]       m0_q;
  reg  [`SBLWM_LANES-1:0]       m0_d;
  reg  [`SBLWM_LANES-1:0]       m1_q;
  reg  [`SBLWM_LANES-1:0]       m1_d;
  reg                           done_d;
  reg                           busy_d;
  reg                           rpend_q;
  reg                           rpend_d;
  reg  [`SBLWM_WORD_W-1:0]      rdata_d;
  reg                           oe_n_d;
  wire [2*`SBLWM_WORD_W-1:0]    mem_rd;
  wire                          out_edge;
  wire                          lo_edge;
  wire                          start;
  wire                          beat1;

  // Lane enables from active-low selects; x18 uses only lanes 0 and 1
  function [`SBLWM_LANES-1:0] lane_en;
    input [`SBLWM_LANES-1:0] sel_n;
    input                    wide;
    reg   [`SBLWM_LANES-1:0] live;
    begin
      live = wide ? `SBLWM_MASK_NONE : `SBLWM_MASK_X18;
      lane_en = ~sel_n & live;
    end
  endfunction

  // Single clock mode takes the input clock pair as output timing
  assign out_edge = SINGLE_CLK_I ? KN_RISE_I : CN_RISE_I;
  assign lo_edge = SINGLE_CLK_I ? K_RISE_I : C_RISE_I;
  // Starts are refused while a burst is still in flight
  assign start = (st_q == ST_IDLE) && K_RISE_I &&
                 !WRITE_PORT_SELECT_N_I;
  assign beat1 = (st_q == ST_BEAT1) && KN_RISE_I;

  // t: select low at K rise; beat 1 at Kn rise in t; commit at t+1
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = ST_BEAT1;
        end
      end
      ST_BEAT1: begin
        if (beat1) begin
          st_d = ST_COMIT;
        end
      end
      ST_COMIT: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Captured words and masks are held together until the commit
  always @* begin
    loc_d = loc_q;
    d0_d = d0_q;
    d1_d = d1_q;
    m0_d = m0_q;
    m1_d = m1_q;

    if (start) begin
      loc_d = ADDR_I;
      d0_d = WDATA_I;
      m0_d = lane_en(BYTE_LANE_WRITE_SELECT_N_I, WIDE_MODE_I);
    end
    if (beat1) begin
      d1_d = WDATA_I;
      m1_d = lane_en(BYTE_LANE_WRITE_SELECT_N_I, WIDE_MODE_I);
    end

    done_d = (st_q == ST_COMIT);
    busy_d = (st_d != ST_IDLE);
  end

  // CE_I low holds the burst exactly where it stands
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_q <= ST_IDLE;
      loc_q <= `SBLWM_LOC_ZERO;
      d0_q <= `SBLWM_WORD_ZERO;
      d1_q <= `SBLWM_WORD_ZERO;
      m0_q <= {`SBLWM_LANES{1'b0}};
      m1_q <= {`SBLWM_LANES{1'b0}};
      WRITE_DONE_O <= 1'b0;
      WRITE_BUSY_O <= 1'b0;
    end else if (CE_I) begin
      st_q <= st_d;
      loc_q <= loc_d;
      d0_q <= d0_d;
      d1_q <= d1_d;
      m0_q <= m0_d;
      m1_q <= m1_d;
      WRITE_DONE_O <= done_d;
      WRITE_BUSY_O <= busy_d;
    end
  end

  // Beat 0 is word A+0 in the low half, beat 1 is A+1 in the high half
  sblwm_mem u_mem (
    .clk_i   (CORE_CLK_I),
    .ce_i    (CE_I),
    .we_i    (st_q == ST_COMIT),
    .waddr_i (loc_q),
    .wlane_i ({m1_q, m0_q}),
    .wdata_i ({d1_q, d0_q}),
    .raddr_i (RADDR_I),
    .rdata_o (mem_rd)
  );

  // Minimal read side: returns both burst words and defines the output tristate state
  always @* begin
    rd_st_d = rd_st_q;
    rpend_d = rpend_q;
    rdata_d = RDATA_O;
    oe_n_d = RDATA_OE_N_O;
    if (K_RISE_I) begin
      rpend_d = READ_I;
    end
    // Word 0 on the output reference edge, word 1 half a cycle later
    case (rd_st_q)
      RD_IDLE: begin
        oe_n_d = 1'b1;
        if (rpend_q && out_edge) begin
          rdata_d = mem_rd[`SBLWM_WORD_W-1:0];
          oe_n_d = 1'b0;
          rpend_d = 1'b0;
          rd_st_d = RD_LO;
        end
      end
      RD_LO: begin
        if (lo_edge) begin
          rdata_d = mem_rd[2*`SBLWM_WORD_W-1:`SBLWM_WORD_W];
          rd_st_d = RD_HI;
        end
      end
      RD_HI: begin
        if (out_edge) begin
          oe_n_d = 1'b1;
          rd_st_d = RD_IDLE;
        end
      end
      default: begin
        rd_st_d = RD_IDLE;
      end
    endcase
  end

  // Output pins stay registered so they never glitch
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rd_st_q <= RD_IDLE;
      rpend_q <= 1'b0;
      RDATA_O <= `SBLWM_WORD_ZERO;
      RDATA_OE_N_O <= 1'b1;
    end else if (CE_I) begin
      rd_st_q <= rd_st_d;
      rpend_q <= rpend_d;
      RDATA_O <= rdata_d;
      RDATA_OE_N_O <= oe_n_d;
    end
  end
endmodule

// ---- testbench/sblwm_checker.sv ----
// Write handshake assertions for the lane mask block
`timescale 1ns/1ps
module sblwm_checker (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic K_RISE_I,
  input wire logic KN_RISE_I,
  input wire logic WRITE_PORT_SELECT_N_I,
  input wire logic WRITE_DONE_O,
  input wire logic WRITE_BUSY_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  wire b  = WRITE_BUSY_O;
  wire d  = WRITE_DONE_O;
  wire kn = CE_I && KN_RISE_I;
  wire st = CE_I && K_RISE_I && !WRITE_PORT_SELECT_N_I && !b;
  sequence beat_s; st ##1 kn; endsequence
  sequence fin_s; b ##1 d && !b; endsequence
  chk_start_busy: assert property (st |=> b) else $error("busy");
  chk_beat_commit: assert property (beat_s |=> fin_s)
    else $error("commit");
  chk_busy_span: assert property (beat_s |-> b [*2] ##1 !b)
    else $error("span");
  chk_done_pulse: assert property (CE_I && d |=> !d) else $error("d");
  chk_done_cause: assert property ($rose(d) |-> !b && $past(b, 2))
    else $error("cause");
  chk_busy_bound: assert property (b |-> ##[1:40] !b) else $error("b");
  chk_idle_hold: assert property (!b && !st |=> !b) else $error("i");
  chk_ce_freeze: assert property (!CE_I |=> $stable({b, d}))
    else $error("freeze");
endmodule
bind sblwm_top sblwm_checker sblwm_checker_i (.CORE_CLK_I, .RST_B_I, .CE_I,
  .K_RISE_I, .KN_RISE_I, .WRITE_PORT_SELECT_N_I, .WRITE_DONE_O,
  .WRITE_BUSY_O);

// ---- testbench/sblwm_ctrl_model.sv ----
// Far-end controller model: alternating input clock edge pulses
`timescale 1ns/1ps
module sblwm_ctrl_model (
  input  wire logic clk_i,
  input  wire logic run_i,
  output logic      k_o,
  output logic      kn_o
);
  initial {k_o, kn_o} = 2'b00;
  // Stopped clocks give no edges, so the pair rests equal
  always @(negedge clk_i) begin
    k_o  <= run_i && !k_o;
    kn_o <= run_i && k_o;
  end
endmodule

// ---- testbench/sram_byte_lane_write_mask_test.sv ----
// Bench: random lane-masked writes, then burst readback
`timescale 1ns/1ps
module sram_byte_lane_write_mask_test;
  logic        clk, rst_n, ce, run, wps_n, wide, rd, k, kn, oe_n, done, sgl;
  logic [7:0]  addr, raddr;
  logic [35:0] wd, rdata;
  logic [3:0]  sel;
  logic [71:0] m [0:7];
  int          failures, n_compared, i, n;
  sblwm_ctrl_model sblwm_ctrl_model_i (.clk_i(clk), .run_i(run), .k_o(k),
    .kn_o(kn));
  sblwm_top sblwm_top_i (.CORE_CLK_I(clk), .RST_B_I(rst_n), .CE_I(ce),
    .WIDE_MODE_I(wide), .K_RISE_I(k), .KN_RISE_I(kn),
    .C_RISE_I(k && !sgl), .CN_RISE_I(kn && !sgl), .SINGLE_CLK_I(sgl),
    .WRITE_PORT_SELECT_N_I(wps_n),
    .ADDR_I(addr), .WDATA_I(wd), .BYTE_LANE_WRITE_SELECT_N_I(sel),
    .READ_I(rd), .RADDR_I(raddr), .RDATA_O(rdata), .RDATA_OE_N_O(oe_n),
    .WRITE_DONE_O(done), .WRITE_BUSY_O());
  initial forever #12.5 clk = ~clk;
  function logic [35:0] mrg(logic [35:0] o, d, logic [3:0] s, logic w);
    for (int j = 0; j < 4; j++)
      if (!s[j] && (w || j < 2)) o[j*9+:9] = d[j*9+:9];
    return o;
  endfunction
  function logic [35:0] r36(); return {4'($urandom), $urandom}; endfunction
  task end_of_test();
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(logic [35:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Bounded wait for read data enable or write completion
  task wt(bit r);
    for (n = 0; n < 20 && (r ? oe_n !== 1'b0 : done !== 1'b1); n++)
      @(posedge clk) #1;
    if (n == 20) failures++;
    if (n == 20) end_of_test();
  endtask
  task on_k();
    @(negedge clk);
    #1;
    if (!k) @(negedge clk);
  endtask
  task wr(logic [2:0] a, logic [35:0] d0, d1, logic [3:0] m0, m1, logic w);
    on_k();
    {wps_n, addr, wd, sel, wide} = {1'b0, 5'h0, a, d0, m0, w};
    @(negedge clk);
    {wps_n, wd, sel} = {1'b1, d1, m1};
    wt(0);
    m[a] = {mrg(m[a][71:36], d1, m1, w), mrg(m[a][35:0], d0, m0, w)};
  endtask
  task rd_chk(logic [2:0] a);
    on_k();
    {rd, raddr} = {1'b1, 5'h0, a};
    @(negedge clk);
    rd = 0;
    wt(1);
    chk(rdata, m[a][35:0]);
    @(posedge clk) #1;
    chk(rdata, m[a][71:36]);
  endtask
  initial begin
    {clk, rst_n, ce, run, wide, rd, sgl, addr, raddr, wd, sel} = 0;
    wps_n = 1;
    i = $urandom(32'h891fe314);
    repeat (10) @(negedge clk);
    {rst_n, ce, run} = 3'b111;
    chk({35'h0, oe_n}, 36'h1);
    for (i = 0; i < 8; i++) wr(3'(i), r36(), r36(), 4'h0, 4'h0, 1);
    wr(3'h2, r36(), r36(), 4'hf, 4'hf, 1);
    for (i = 0; i < 40; i++)
      wr(3'($urandom), r36(), r36(), 4'($urandom), 4'($urandom),
        1'($urandom));
    {ce, run} = 2'b00;
    repeat (3) @(negedge clk);
    {ce, run} = 2'b11;
    // Second pass reads in single clock mode, output clock pair idle
    for (i = 0; i < 16; i++) begin
      sgl = i[3];
      rd_chk(3'(i));
    end
    end_of_test();
  end
endmodule
